/* sas_atten_ctrl.sv */
// Notes on behaviour
// - Sixteen-bit shifter, eight-bit comparator, six-bit latch.
// - Bits arrive LSB first on rising clock.
// - High strobe masks the serial clock.
// - Strobe pulse after sixteen bits updates attenuation.
// - First byte attenuation, last byte address.
// - Attenuation code is bits six to one.
// - Latch only on matching, upper-zero address.
// - Code is binary weighted, half-dB steps.
// - Power-up state is maximum attenuation.
// - Empty shifter with address zero gives zero.
// - Empty shifter, nonzero address keeps maximum.
// - Three strap pins give eight addresses.
`timescale 1ns/100ps

module sas_atten_ctrl
    import sas_pkg::*;
#(
    parameter int SETTLE_CYCLES = sas_pkg::SAS_SETTLE_CYCLES
) (
    // System clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Serial link
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic latch_strobe_in,
    // Address straps
    input wire logic [2:0] addr_select_pins_in,
    // Attenuator control
    output logic [5:0] atten_code_out,
    output logic [11:0] atten_cdb_out,
    // Status
    output sas_pkg::sas_event_s event_out,
    output logic [7:0] last_addr_out,
    output logic busy_out
);

    // ==========================================================
    // Functions
    function automatic logic addr_ok(
        input logic [7:0] addr_byte,
        input logic [2:0] pins
    );
        logic [2:0] match_bits;
        logic [4:0] zero_bits;
        match_bits = addr_byte[SAS_MATCH_W-1:0];
        zero_bits = addr_byte[SAS_BYTE_W-1:SAS_MATCH_W];
        return (match_bits == pins) &&
            (zero_bits == SAS_ZERO_FIELD);
    endfunction : addr_ok

    function automatic logic [5:0] code_of(input logic [7:0] atten_byte);
        return atten_byte[SAS_CODE_LSB+SAS_CODE_W-1:SAS_CODE_LSB];
    endfunction : code_of

    function automatic logic [11:0] cdb_of(input logic [5:0] code);
        return 12'(code * SAS_STEP_CDB);
    endfunction : cdb_of

    // ==========================================================
    // Link-domain reset
    // Assertion is immediate, release follows the link clock so
    // that no shift edge races the reset removal.
    logic link_rst_b;

    sas_sync2 #(
        .WIDTH(1)
    ) u_link_rst (
        .clock_in(serial_clk_in),
        .rst_b_in(rst_b_in),
        .async_in(1'b1),
        .sync_out(link_rst_b)
    );

    // ==========================================================
    // Serial shifter on the link clock
    sas_frame_s link_frame;
    logic [4:0] link_count;

    sas_shifter u_shifter (
        .serial_clk_in(serial_clk_in),
        .link_rst_b_in(link_rst_b),
        .serial_data_in(serial_data_in),
        .latch_strobe_in(latch_strobe_in),
        .frame_out(link_frame),
        .bit_count_out(link_count)
    );

    // ==========================================================
    // Pin synchronisers
    logic strobe_sync;
    logic [2:0] pins_sync;

    sas_sync2 #(
        .WIDTH(1)
    ) u_strobe_sync (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .async_in(latch_strobe_in),
        .sync_out(strobe_sync)
    );

    sas_sync2 #(
        .WIDTH(SAS_MATCH_W)
    ) u_pins_sync (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .async_in(addr_select_pins_in),
        .sync_out(pins_sync)
    );

    // ==========================================================
    // Strobe edge
    // The previous level resets low, so a strobe already high at
    // power-up counts as a pulse.
    logic strobe_prev;
    wire strobe_rise = strobe_sync && !strobe_prev;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strobe_prev <= 1'b0;
        end else begin
            strobe_prev <= strobe_sync;
        end
    end

    // ==========================================================
    // Frame capture
    // The link word is frozen while the strobe is high because the
    // serial clock is masked, so it is read only after the strobe
    // has passed the synchroniser and a settle delay.
    sas_frame_s frame;
    logic [4:0] frame_count;
    logic [3:0] settle;
    sas_state_e state;
    sas_state_e next_state;

    wire settle_done = (settle == 4'(SETTLE_CYCLES));
    wire take_frame = (state == SAS_ST_SETTLE) && settle_done;
    wire match = addr_ok(frame.addr_byte, pins_sync);
    wire apply_now = (state == SAS_ST_APPLY);
    wire [5:0] new_code = code_of(frame.atten_byte);
    wire short_now = (frame_count != SAS_FULL_COUNT);

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            frame <= '0;
            frame_count <= '0;
        end else if (take_frame) begin
            frame <= link_frame;
            frame_count <= link_count;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            settle <= '0;
        end else if (state == SAS_ST_SETTLE && !settle_done) begin
            settle <= 4'(settle + 4'h1);
        end else if (state != SAS_ST_SETTLE) begin
            settle <= '0;
        end
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            SAS_ST_POWERUP: begin
                next_state = SAS_ST_IDLE;
            end
            SAS_ST_IDLE: begin
                if (strobe_rise) begin
                    next_state = SAS_ST_SETTLE;
                end
            end
            SAS_ST_SETTLE: begin
                if (settle_done) begin
                    next_state = SAS_ST_APPLY;
                end
            end
            SAS_ST_APPLY: begin
                next_state = SAS_ST_HOLD;
            end
            SAS_ST_HOLD: begin
                if (!strobe_sync) begin
                    next_state = SAS_ST_IDLE;
                end
            end
            default: begin
                next_state = SAS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= SAS_ST_POWERUP;
        end else begin
            state <= next_state;
        end
    end

    assign busy_out = (state != SAS_ST_IDLE);

    // ==========================================================
    // Attenuation latch
    // A zero frame matches only address zero, which gives the
    // zero-attenuation state; any other strap keeps the maximum.
    localparam logic [11:0] MAX_CDB = 12'(SAS_MAX_CODE * SAS_STEP_CDB);
    logic [5:0] next_code;

    assign next_code = (apply_now && match) ? new_code :
        atten_code_out;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            atten_code_out <= SAS_MAX_CODE;
            atten_cdb_out <= MAX_CDB;
        end else begin
            atten_code_out <= next_code;
            atten_cdb_out <= cdb_of(next_code);
        end
    end

    // ==========================================================
    // Status
    // A frame with other than sixteen bits is still applied when
    // the address matches; the flag only reports it.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            event_out <= '0;
            last_addr_out <= '0;
        end else begin
            event_out.accepted <= apply_now && match;
            event_out.refused <= apply_now && !match;
            event_out.short_frame <= apply_now && short_now;
            if (apply_now) begin
                last_addr_out <= frame.addr_byte;
            end
        end
    end

endmodule : sas_atten_ctrl

/* sas_pkg.sv */
package sas_pkg;

    // ==========================================================
    // Frame geometry
    localparam int SAS_BYTE_W = 8;
    localparam int SAS_FRAME_W = 16;
    localparam int SAS_CODE_W = 6;
    localparam int SAS_CODE_LSB = 1;
    localparam int SAS_MATCH_W = 3;
    localparam int SAS_ZERO_W = 5;
    localparam int SAS_COUNT_W = 5;
    localparam int SAS_CDB_W = 12;

    // ==========================================================
    // Reset values and weights
    localparam logic [5:0] SAS_MAX_CODE = 6'h3F;
    localparam logic [5:0] SAS_MIN_CODE = 6'h00;
    localparam logic [4:0] SAS_FULL_COUNT = 5'h10;
    localparam logic [4:0] SAS_COUNT_CAP = 5'h1F;
    localparam logic [4:0] SAS_ZERO_FIELD = 5'h00;
    localparam logic [11:0] SAS_STEP_CDB = 12'h032;

    // ==========================================================
    // Timing
    localparam int SAS_SYS_PERIOD_PS = 5000;
    localparam int SAS_SETTLE_NS = 10;
    localparam int SAS_SETTLE_CYCLES =
        (SAS_SETTLE_NS * 1000 + SAS_SYS_PERIOD_PS - 1) / SAS_SYS_PERIOD_PS;
    localparam int SAS_SETTLE_W = 4;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] addr_byte;
        logic [7:0] atten_byte;
    } sas_frame_s;

    typedef struct packed {
        logic accepted;
        logic refused;
        logic short_frame;
    } sas_event_s;

    typedef enum logic [4:0] {
        SAS_ST_POWERUP = 5'h01,
        SAS_ST_IDLE = 5'h02,
        SAS_ST_SETTLE = 5'h04,
        SAS_ST_APPLY = 5'h08,
        SAS_ST_HOLD = 5'h10
    } sas_state_e;

endpackage : sas_pkg

/* sas_sync2.sv */
`timescale 1ns/100ps

module sas_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Two stages
    // The first stage is read by the second stage only.
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : sas_sync2

/* sas_shifter.sv */
`timescale 1ns/100ps

module sas_shifter
    import sas_pkg::*;
(
    // Link clock and reset
    input wire logic serial_clk_in,
    input wire logic link_rst_b_in,
    // Serial pins
    input wire logic serial_data_in,
    input wire logic latch_strobe_in,
    // Parallel view
    output sas_pkg::sas_frame_s frame_out,
    output logic [4:0] bit_count_out
);

    // ==========================================================
    // Shift register
    // Entry is at the top, so the first bit ends in bit zero.
    logic strobe_seen;
    wire shift_en = !latch_strobe_in;
    wire sas_frame_s next_frame =
        {serial_data_in, frame_out[SAS_FRAME_W-1:1]};
    wire [4:0] next_count = strobe_seen ? 5'h01 :
        (bit_count_out == SAS_COUNT_CAP) ? SAS_COUNT_CAP :
        5'(bit_count_out + 5'h01);

    always_ff @(posedge serial_clk_in or negedge link_rst_b_in) begin
        if (!link_rst_b_in) begin
            frame_out <= '0;
            bit_count_out <= '0;
            strobe_seen <= 1'b0;
        end else if (shift_en) begin
            frame_out <= next_frame;
            bit_count_out <= next_count;
            strobe_seen <= 1'b0;
        end else begin
            strobe_seen <= 1'b1;
        end
    end

endmodule : sas_shifter

/* sas_atten_chk.sv */
`timescale 1ns/100ps

// ====
// Checker
module sas_atten_chk
    import sas_pkg::*;
#(
    parameter int SETTLE_CYCLES = 2
) (
    // Clocks and pins
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic latch_strobe_in,
    input wire logic [2:0] addr_select_pins_in,
    // Results
    input wire logic [5:0] atten_code_out,
    input wire logic [11:0] atten_cdb_out,
    input wire sas_pkg::sas_event_s event_out,
    input wire logic [7:0] last_addr_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    sequence verdict_s;
        event_out.accepted || event_out.refused;
    endsequence
    cdb_weight_a: assert property (
        atten_cdb_out == 12'(atten_code_out) * SAS_STEP_CDB)
        else $error("cdb not code times step");
    code_hold_a: assert property (
        $changed(atten_code_out) |-> event_out.accepted)
        else $error("code changed without accept");
    refuse_hold_a: assert property (
        event_out.refused |-> $stable(atten_code_out))
        else $error("code changed on refusal");
    verdict_excl_a: assert property (
        !(event_out.accepted && event_out.refused))
        else $error("accept and refuse together");
    accept_pulse_a: assert property (
        event_out.accepted |=> !event_out.accepted)
        else $error("accept longer than one cycle");
    strobe_verdict_a: assert property (
        $rose(latch_strobe_in) |-> ##[2:12] verdict_s)
        else $error("no verdict after strobe");
    addr_match_a: assert property (
        event_out.accepted |->
            last_addr_out == {5'h00, addr_select_pins_in})
        else $error("accepted foreign address");
    addr_miss_a: assert property (
        event_out.refused |->
            last_addr_out != {5'h00, addr_select_pins_in})
        else $error("refused own address");
    quiet_a: assert property (
        (!latch_strobe_in) [*8] |->
            !(event_out.accepted || event_out.refused))
        else $error("verdict without strobe");
endmodule : sas_atten_chk

bind sas_atten_ctrl sas_atten_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .clock_in, .rst_b_in, .latch_strobe_in, .addr_select_pins_in,
    .atten_code_out, .atten_cdb_out, .event_out, .last_addr_out);

/* sas_host.sv */
`timescale 1ns/100ps

// ====
// Serial host model; between frames the link clock pulses only inside the strobe, twice per strobe pulse.
module sas_host (
    // Serial control lines
    output logic serial_clk_out,
    output logic serial_data_out,
    output logic latch_strobe_out
);
    initial begin
        serial_clk_out = 1'b0;
        serial_data_out = 1'b0;
        latch_strobe_out = 1'b0;
    end
    task automatic send_bit(input logic b);
        serial_data_out = b;
        #31.25 serial_clk_out = 1'b1;
        #62.5 serial_clk_out = 1'b0;
        #31.25;
    endtask : send_bit
    task automatic send_frame(input logic [15:0] frame, input logic extra);
        if (extra) begin
            send_bit(~frame[0]);
        end
        for (int i = 0; i < 16; i++) send_bit(frame[i]);
        // A released data line must not look like a held bit.
        serial_data_out = ~frame[15];
    endtask : send_frame
    task automatic strobe_pulse();
        latch_strobe_out = 1'b1;
        #10;
        repeat (2) send_bit(~serial_data_out);
        #10 latch_strobe_out = 1'b0;
    endtask : strobe_pulse
endmodule : sas_host

/* tb_top.sv */
`timescale 1ns/100ps

// ====
// Testbench
module tb_top;
    import sas_pkg::*;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b1;
    logic [2:0] pins = 3'h0;
    wire logic sclk, sdata, strobe;
    logic [5:0] code_out;
    logic [11:0] cdb_out;
    logic busy;
    sas_event_s ev;
    logic [7:0] last_addr;
    logic acc_seen = 1'b0, ref_seen = 1'b0, short_seen = 1'b0;
    logic [5:0] model_code;
    logic [7:0] atten, addr;
    logic [31:0] r;
    int err_total = 0, cmp_count = 0, cycles = 0, seed = 32;

    always #2.5 clock_in = ~clock_in;
    sas_host HOST (.serial_clk_out(sclk), .serial_data_out(sdata),
        .latch_strobe_out(strobe));
    sas_atten_ctrl #(.SETTLE_CYCLES(2)) DUT (.clock_in(clock_in),
        .rst_b_in(rst_b_in), .serial_clk_in(sclk), .serial_data_in(sdata),
        .latch_strobe_in(strobe), .addr_select_pins_in(pins),
        .atten_code_out(code_out), .atten_cdb_out(cdb_out), .event_out(ev),
        .last_addr_out(last_addr), .busy_out(busy));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    always @(posedge clock_in) begin
        cycles++;
        if (ev.accepted === 1'b1) acc_seen = 1'b1;
        if (ev.refused === 1'b1) ref_seen = 1'b1;
        if (ev.short_frame === 1'b1) short_seen = 1'b1;
        if (cycles == 30000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic compare(string name, logic [11:0] exp, logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : compare
    function automatic logic [11:0] cdb_of(logic [5:0] c);
        return {6'h00, c} * 12'h032;
    endfunction : cdb_of
    task automatic latch_check(logic [15:0] frame, logic sh_exp);
        logic ok;
        ok = frame[15:11] == 5'h00 && frame[10:8] == pins;
        acc_seen = 1'b0;
        ref_seen = 1'b0;
        short_seen = 1'b0;
        #1;
        HOST.strobe_pulse();
        for (int i = 0; i < 20 && !(acc_seen | ref_seen); i++)
            @(posedge clock_in);
        // The sequencer needs the strobe low through the synchroniser.
        repeat (4) @(posedge clock_in);
        #1;
        if (ok) model_code = frame[6:1];
        compare("accepted", {11'h000, ok}, {11'h000, acc_seen});
        compare("refused", {11'h000, !ok}, {11'h000, ref_seen});
        compare("short", {11'h000, sh_exp}, {11'h000, short_seen});
        compare("busy", 12'h000, {11'h000, busy});
        compare("code", {6'h00, model_code}, {6'h00, code_out});
        compare("cdb", cdb_of(model_code), cdb_out);
        compare("address", {4'h0, frame[15:8]}, {4'h0, last_addr});
    endtask : latch_check

    initial begin
        // A real falling edge, so both clock domains see the reset.
        #1 rst_b_in = 1'b0;
        repeat (2) @(posedge clock_in);
        #1 rst_b_in = 1'b1;
        model_code = SAS_MAX_CODE;
        repeat (4) @(posedge clock_in);
        #1;
        compare("power-up", 12'h03F, {6'h00, code_out});
        compare("idle", 12'h000, {11'h000, busy});
        pins = 3'h5;
        repeat (5) @(posedge clock_in);
        latch_check(16'h0000, 1'b1);
        pins = 3'h0;
        repeat (5) @(posedge clock_in);
        latch_check(16'h0000, 1'b1);
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            atten = i == 0 ? 8'h81 : i == 1 ? 8'hFE : r[15:8];
            pins = i < 8 ? i[2:0] : r[18:16];
            addr = {5'h00, pins};
            if (r[1:0] == 2'h2) addr[2:0] = pins ^ (3'h1 << (i % 3));
            if (r[1:0] == 2'h3) addr[7:3] = 5'h01 << (i % 5);
            HOST.send_frame({addr, atten}, r[5]);
            latch_check({addr, atten}, r[5]);
            // Masked edges during the strobe must leave the word intact.
            if (i == 4) latch_check({addr, atten}, r[5]);
        end
        wrap_up();
    end
endmodule : tb_top
